// ### hdl/deg_cfg.svh
`ifndef DEG_CFG_SVH
`define DEG_CFG_SVH
`define DEG_ADDR_ID 4'h0
`define DEG_ADDR_CTRL 4'h1
`define DEG_ADDR_STAT 4'h2
`define DEG_ADDR_BP_BASE 4'h4
`define DEG_ADDR_WP_BASE 4'h8
`define DEG_ADDR_CTX 4'hC
`define DEG_CTRL_MON 0
`define DEG_CTRL_HALT 1
`define DEG_CTRL_SSTEP 2
`define DEG_CTRL_VCATCH 3
`define DEG_CTRL_RESET 32'h0000_0000
`endif

// ### hdl/deg_pkg.sv
package deg_pkg;
    typedef enum logic [1:0] {
        DEG_ACT_NONE,
        DEG_ACT_EXC,
        DEG_ACT_HALT,
        DEG_ACT_PEND
    } deg_action_t;
    typedef enum {
        DEG_RUN,
        DEG_STEP_ARMED,
        DEG_HALTED
    } deg_state_t;
endpackage

// ### hdl/deg_event_gen.sv
`timescale 1ns/100ps
`include "deg_cfg.svh"
// Operation
// - Halt instruction halts when debugger connected, permitted
// - Wide breakpoint instruction raises exception, never halts
// - Breakpoint compares executing address, no code change
// - Watchpoint compares load/store address, raises event
// - Halting mode: event halts core, stops fetch
// - Each event resolves to one action
// - Never both exception and halt
// - Secure with untrusted debugger: no halt
// - Bp/wp exception only when debug enabled
// - Step events only while exceptions enabled
// - Software breakpoints raise exception, unmaskable, unless a pending halt is taken in the same cycle
// - Synchronous events tied to causing instruction
// - Context breakpoint matches context or VM tag
// - Breakpoints qualified by mode, level, security
// - Address breakpoint linkable to context breakpoint
// - Watchpoint qualified and linkable to context
// - Watchpoint filters loads, stores or both
// - Watchpoint ignores instruction fetches
// - Step executes one instruction, then traps
// - Other synchronous exception may replace step
// - Vector catch narrow stage 1 only, exceptions
module deg_event_gen #(
    parameter int NUM_BP = 6,
    parameter int NUM_WP = 4,
    // Arbitrary value
    parameter logic [7:0] DEG_DEVICE_CODE = 8'h5A
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Register port
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    // Retiring instruction
    input wire logic i_insn_valid,
    input wire logic [31:0] i_insn_addr,
    input wire logic i_insn_halt_entry,
    input wire logic i_insn_wide_brk,
    input wire logic i_insn_narrow_brk,
    input wire logic i_insn_other_exc,
    // Data access
    input wire logic i_data_valid,
    input wire logic i_data_fetch,
    input wire logic i_data_store,
    input wire logic [31:0] i_data_addr,
    // Context
    input wire logic [1:0] i_exc_level,
    input wire logic i_secure,
    input wire logic i_narrow_state,
    input wire logic i_stage1_regime,
    input wire logic i_vector_taken,
    input wire logic [15:0] i_context_id,
    input wire logic [7:0] i_vm_tag,
    input wire logic i_debug_enable,
    // External debugger pins
    input wire logic i_dbg_connected,
    input wire logic i_dbg_secure_trusted,
    input wire logic i_dbg_restart,
    // Actions
    output logic o_debug_exc,
    output logic o_halt,
    output logic o_fetch_stop
);
    import deg_pkg::*;

    initial begin
        if (NUM_BP < 1 || NUM_BP > 4 || NUM_WP < 1 || NUM_WP > 4) begin
            $error("deg_event_gen: 1 to 4 breakpoints and watchpoints");
        end
    end

    // Pin synchronisers
    logic [2:0] sync1;
    logic [2:0] sync2;
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {i_dbg_restart, i_dbg_secure_trusted, i_dbg_connected};
            sync2 <= sync1;
        end
    end
    logic dbg_conn;
    logic dbg_trusted;
    logic dbg_restart;
    assign dbg_conn = sync2[0];
    assign dbg_trusted = sync2[1];
    assign dbg_restart = sync2[2];

    // Registers
    logic [31:0] ctrl;
    logic [31:0] bp_addr [NUM_BP];
    logic [31:0] bp_cfg [NUM_BP];
    logic [31:0] wp_addr [NUM_WP];
    logic [31:0] ctx_cmp;
    logic sel_bp_cfg;
    assign sel_bp_cfg = i_reg_wdata[31];

    // Control: bit0 monitor, bit1 halting, bit2 step, bit3 vector catch
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl <= `DEG_CTRL_RESET;
            ctx_cmp <= 32'h0000_0000;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `DEG_ADDR_CTRL) begin
                ctrl <= i_reg_wdata;
            end
            if (i_reg_addr == `DEG_ADDR_CTX) begin
                ctx_cmp <= i_reg_wdata;
            end
        end
    end

    // Breakpoint cfg: [31] secure, [30] nonsecure, [29:26] EL mask,
    // [25] enable, [24] link to context, [23] context type; VM tag selected by ctx_cmp[31] in nonsecure state
    // Watchpoint addr word: [31:2] address, [1] load, [0] store
    logic [NUM_BP-1:0] bp_hit;
    logic [NUM_WP-1:0] wp_hit;
    logic ctx_match;
    assign ctx_match = (!i_secure && ctx_cmp[31]) ? (i_vm_tag == ctx_cmp[23:16])
                                                  : (i_context_id == ctx_cmp[15:0]);
    genvar g;
    generate
        for (g = 0; g < NUM_BP; g++) begin : g_bp
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    bp_addr[g] <= 32'h0000_0000;
                    bp_cfg[g] <= 32'h0000_0000;
                end else if (i_reg_wr && i_reg_addr == `DEG_ADDR_BP_BASE + 4'(g)) begin
                    if (sel_bp_cfg && i_reg_wdata[30]) begin
                        bp_cfg[g] <= {i_reg_wdata[29:0], 2'b00};
                    end else begin
                        bp_addr[g] <= i_reg_wdata;
                    end
                end
            end
            logic qual;
            assign qual = bp_cfg[g][29 - 32'(i_exc_level)] &&
                          (i_secure ? bp_cfg[g][31] : bp_cfg[g][30]);
            assign bp_hit[g] = bp_cfg[g][25] && qual && i_insn_valid &&
                (bp_cfg[g][23] ? ctx_match
                               : ((i_insn_addr == bp_addr[g]) && (!bp_cfg[g][24] || ctx_match)));
        end
        for (g = 0; g < NUM_WP; g++) begin : g_wp
            always_ff @(posedge i_clk_sys or negedge i_rstn) begin
                if (!i_rstn) begin
                    wp_addr[g] <= 32'h0000_0000;
                end else if (i_reg_wr && i_reg_addr == `DEG_ADDR_WP_BASE + 4'(g)) begin
                    wp_addr[g] <= i_reg_wdata;
                end
            end
            assign wp_hit[g] = i_data_valid && !i_data_fetch &&
                (i_data_addr[31:2] == wp_addr[g][31:2]) &&
                (i_data_store ? wp_addr[g][0] : wp_addr[g][1]) &&
                bp_cfg[0][29 - 32'(i_exc_level)] &&
                (i_secure ? bp_cfg[0][31] : bp_cfg[0][30]) &&
                (!bp_cfg[0][24] || ctx_match);
        end
    endgenerate

    // Event resolution
    logic halt_allowed;
    logic mon_mode;
    logic halt_mode;
    logic step_due;
    logic vcatch;
    logic hwpt;
    deg_state_t state;
    deg_action_t action;
    logic pending;
    assign mon_mode = ctrl[`DEG_CTRL_MON];
    assign halt_mode = ctrl[`DEG_CTRL_HALT];
    assign halt_allowed = dbg_conn && (!i_secure || dbg_trusted);
    assign hwpt = (|bp_hit) || (|wp_hit);
    assign vcatch = ctrl[`DEG_CTRL_VCATCH] && i_vector_taken && i_narrow_state &&
                    i_stage1_regime && i_debug_enable;
    assign step_due = (state == DEG_STEP_ARMED) && i_insn_valid && !i_insn_other_exc &&
                      i_debug_enable && mon_mode;

    always_comb begin
        action = DEG_ACT_NONE;
        if (i_insn_valid && (i_insn_wide_brk || i_insn_narrow_brk)) begin
            action = DEG_ACT_EXC;
        end else if (i_insn_valid && i_insn_halt_entry) begin
            action = halt_allowed ? DEG_ACT_HALT : DEG_ACT_PEND;
        end else if (hwpt && halt_mode) begin
            action = halt_allowed ? DEG_ACT_HALT : DEG_ACT_PEND;
        end else if (hwpt && mon_mode && i_debug_enable) begin
            action = DEG_ACT_EXC;
        end else if (step_due || vcatch) begin
            action = DEG_ACT_EXC;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            pending <= 1'b0;
        end else if (state != DEG_HALTED && action == DEG_ACT_PEND) begin
            pending <= 1'b1;
        end else if (pending && halt_allowed && state != DEG_HALTED) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= DEG_RUN;
            o_debug_exc <= 1'b0;
            o_halt <= 1'b0;
            o_fetch_stop <= 1'b0;
        end else begin
            o_debug_exc <= 1'b0;
            case (state)
                DEG_RUN, DEG_STEP_ARMED: begin
                    if (action == DEG_ACT_HALT || (pending && halt_allowed)) begin
                        state <= DEG_HALTED;
                        o_halt <= 1'b1;
                        o_fetch_stop <= 1'b1;
                    end else if (action == DEG_ACT_EXC) begin
                        o_debug_exc <= 1'b1;
                        state <= DEG_RUN;
                    end else if (ctrl[`DEG_CTRL_SSTEP] && state == DEG_RUN && i_insn_valid) begin
                        // Stepped instruction retires first, trap on the next
                        state <= DEG_STEP_ARMED;
                    end else if (!ctrl[`DEG_CTRL_SSTEP]) begin
                        state <= DEG_RUN;
                    end else if (i_insn_valid && i_insn_other_exc) begin
                        state <= DEG_RUN;
                    end
                end
                DEG_HALTED: begin
                    if (dbg_restart) begin
                        state <= DEG_RUN;
                        o_halt <= 1'b0;
                        o_fetch_stop <= 1'b0;
                    end
                end
                default: begin
                    state <= DEG_RUN;
                end
            endcase
        end
    end

    // Read port
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_reg_rd) begin
            o_reg_rdata <= 32'h0000_0000;
            case (i_reg_addr)
                `DEG_ADDR_ID: o_reg_rdata <= {16'h0000, DEG_DEVICE_CODE, 4'(NUM_WP), 4'(NUM_BP)};
                `DEG_ADDR_CTRL: o_reg_rdata <= ctrl;
                `DEG_ADDR_STAT: o_reg_rdata <= {28'h000_0000, pending, o_halt,
                                                state == DEG_STEP_ARMED, halt_allowed};
                `DEG_ADDR_CTX: o_reg_rdata <= ctx_cmp;
                default: begin
                    if (i_reg_addr >= `DEG_ADDR_BP_BASE &&
                        i_reg_addr < `DEG_ADDR_BP_BASE + 4'(NUM_BP) &&
                        i_reg_addr < `DEG_ADDR_WP_BASE) begin
                        o_reg_rdata <= bp_addr[2'(i_reg_addr - `DEG_ADDR_BP_BASE)];
                    end else if (i_reg_addr >= `DEG_ADDR_WP_BASE &&
                                 i_reg_addr < `DEG_ADDR_WP_BASE + 4'(NUM_WP)) begin
                        o_reg_rdata <= wp_addr[2'(i_reg_addr - `DEG_ADDR_WP_BASE)];
                    end
                end
            endcase
        end
    end
endmodule

// ### testbench/deg_event_gen_monitor.sv
`timescale 1ns/100ps
module deg_event_gen_chk (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // Core side
    input wire logic i_insn_valid,
    input wire logic i_insn_wide_brk,
    input wire logic i_insn_narrow_brk,
    input wire logic i_data_valid,
    input wire logic i_data_fetch,
    input wire logic i_vector_taken,
    input wire logic i_narrow_state,
    input wire logic i_stage1_regime,
    input wire logic i_secure,
    // Debugger pins
    input wire logic i_dbg_connected,
    input wire logic i_dbg_secure_trusted,
    input wire logic i_dbg_restart,
    // Actions
    input wire logic o_debug_exc,
    input wire logic o_halt,
    input wire logic o_fetch_stop
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    AST_ONE_ACTION: assert property (!(o_debug_exc && $rose(o_halt)))
        else $error("exception and halt from one event");
    AST_WIDE_BRK: assert property (i_insn_valid && i_insn_wide_brk && !o_halt |=> o_debug_exc)
        else $error("wide breakpoint gave no exception");
    AST_NARROW_BRK: assert property (i_insn_valid && i_insn_narrow_brk && !o_halt |=> o_debug_exc)
        else $error("narrow breakpoint gave no exception");
    AST_FETCH_STOP: assert property (o_halt |-> o_fetch_stop)
        else $error("halted core still fetching");
    AST_HALT_CONN: assert property ($rose(o_halt) |-> $past(i_dbg_connected, 3))
        else $error("halt without debugger");
    AST_SECURE: assert property ($rose(o_halt) |-> !($past(i_secure) && !$past(i_dbg_secure_trusted, 3)))
        else $error("halt in secure state with untrusted debugger");
    AST_NO_FETCH_WP: assert property (i_data_valid && i_data_fetch && !i_insn_valid
        && !i_vector_taken |=> !o_debug_exc)
        else $error("fetch address raised an event");
    AST_SYNC_ONLY: assert property (!i_insn_valid && !i_data_valid
        && !(i_vector_taken && i_narrow_state && i_stage1_regime) |=> !o_debug_exc)
        else $error("exception without a cause");
    AST_HALT_STANDS: assert property ($fell(o_halt) |-> $past(i_dbg_restart, 2)
        || $past(i_dbg_restart, 3) || $past(i_dbg_restart, 4))
        else $error("halt left without restart");
endmodule
bind deg_event_gen deg_event_gen_chk chk_u (.i_clk_sys, .i_rstn, .i_insn_valid,
    .i_insn_wide_brk, .i_insn_narrow_brk, .i_data_valid, .i_data_fetch, .i_vector_taken,
    .i_narrow_state, .i_stage1_regime, .i_secure, .i_dbg_connected, .i_dbg_secure_trusted,
    .i_dbg_restart, .o_debug_exc, .o_halt, .o_fetch_stop);

// ### testbench/deg_dbg_host.sv
`timescale 1ns/100ps
module deg_dbg_host (
    // Clock
    input wire logic i_clk_sys,
    // Debugger pins
    output logic o_connected,
    output logic o_trusted,
    output logic o_restart
);
    initial begin
        o_connected = 1'b1;
        o_trusted = 1'b0;
        o_restart = 1'b0;
    end
    // Held four cycles to clear the pin synchroniser
    task automatic resume();
        @(posedge i_clk_sys) o_restart <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        o_restart <= 1'b0;
    endtask
endmodule

// ### testbench/tb.sv
`timescale 1ns/100ps
`include "deg_cfg.svh"
module tb;
    import deg_pkg::*;
    localparam logic [7:0] CODE = 8'h3C; // Arbitrary value
    localparam logic [31:0] BPA = 32'h0000_1000;
    logic i_clk_sys, i_rstn, wr, rd, iv, hent, wbrk, nbrk, oexc, dv, df, ds;
    logic sec, nar, st1, vec, den, con, tru, rsp, exc, halt_entry_instruction, fst;
    logic [3:0] ra;
    logic [31:0] wd, rdat, ia, da;
    int fails = 0, n_compared = 0, cyc = 0;
    deg_event_gen #(.NUM_BP(4), .NUM_WP(4), .DEG_DEVICE_CODE(CODE)) dut_u (
        .i_clk_sys, .i_rstn, .i_reg_addr(ra), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdat), .i_insn_valid(iv), .i_insn_addr(ia), .i_insn_halt_entry(hent),
        .i_insn_wide_brk(wbrk), .i_insn_narrow_brk(nbrk), .i_insn_other_exc(oexc),
        .i_data_valid(dv), .i_data_fetch(df), .i_data_store(ds), .i_data_addr(da),
        .i_exc_level(2'h1), .i_secure(sec), .i_narrow_state(nar), .i_stage1_regime(st1),
        .i_vector_taken(vec), .i_context_id(16'h0000), .i_vm_tag(8'h00), .i_debug_enable(den),
        .i_dbg_connected(con), .i_dbg_secure_trusted(tru), .i_dbg_restart(rsp),
        .o_debug_exc(exc), .o_halt(halt_entry_instruction), .o_fetch_stop(fst));
    deg_dbg_host host_u (.i_clk_sys, .o_connected(con), .o_trusted(tru), .o_restart(rsp));
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys) begin ra <= a; wd <= d; wr <= 1'b1; end
        @(posedge i_clk_sys) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        @(posedge i_clk_sys) begin ra <= a; rd <= 1'b1; end
        @(posedge i_clk_sys) rd <= 1'b0;
        #1 chk(rdat, e);
    endtask
    // Flags: halt entry, wide brk, narrow brk, other exception
    task automatic ins(input logic [31:0] a, input logic [3:0] f, input logic e, h);
        @(posedge i_clk_sys) begin iv <= 1'b1; ia <= a; {hent, wbrk, nbrk, oexc} <= f; end
        @(posedge i_clk_sys) {iv, hent, wbrk, nbrk, oexc} <= 5'h00;
        #1 chk({30'h0, exc, halt_entry_instruction}, {30'h0, e, h});
    endtask
    task automatic dac(input logic [31:0] a, input logic s, f, e);
        @(posedge i_clk_sys) begin dv <= 1'b1; da <= a; ds <= s; df <= f; end
        @(posedge i_clk_sys) dv <= 1'b0;
        #1 chk({31'h0, exc}, {31'h0, e});
    endtask
    task automatic wait_halt(input logic e);
        for (int k = 0; k < 12 && halt_entry_instruction !== e; k++) @(posedge i_clk_sys);
        #1 chk({30'h0, halt_entry_instruction, fst}, {30'h0, e, e});
    endtask
    task automatic t_regs();
        rreg(`DEG_ADDR_ID, {16'h0000, CODE, 4'h4, 4'h4});
        rreg(4'h3, 32'h0000_0000);
        wreg(`DEG_ADDR_CTRL, 32'h0000_0002);
        rreg(`DEG_ADDR_CTRL, 32'h0000_0002);
        wreg(4'h4, 32'hFF80_0000);
        wreg(4'h4, BPA);
        $display("regs done");
    endtask
    task automatic t_brk();
        ins(32'h0000_0040, 4'h4, 1'b1, 1'b0);
        ins(32'h0000_0044, 4'h2, 1'b1, 1'b0);
        $display("brk done");
    endtask
    task automatic t_halt();
        ins(BPA, 4'h0, 1'b0, 1'b1);
        wait_halt(1'b1);
        host_u.resume();
        wait_halt(1'b0);
        ins(32'h0000_0080, 4'h8, 1'b0, 1'b1);
        host_u.resume();
        wait_halt(1'b0);
        $display("halt done");
    endtask
    task automatic t_secure();
        sec <= 1'b1;
        ins(32'h0000_0080, 4'h8, 1'b0, 1'b0);
        rreg(`DEG_ADDR_STAT, 32'h0000_0008);
        sec <= 1'b0;
        wait_halt(1'b1);
        rreg(`DEG_ADDR_STAT, 32'h0000_0005);
        host_u.resume();
        wait_halt(1'b0);
        $display("secure done");
    endtask
    task automatic t_mon();
        wreg(`DEG_ADDR_CTRL, 32'h0000_0001);
        den <= 1'b1;
        ins(BPA, 4'h0, 1'b1, 1'b0);
        ins(BPA + 32'h4, 4'h0, 1'b0, 1'b0);
        wreg(4'h8, 32'h0000_2002);
        dac(32'h0000_2000, 1'b0, 1'b0, 1'b1);
        dac(32'h0000_2000, 1'b1, 1'b0, 1'b0);
        dac(32'h0000_2000, 1'b0, 1'b1, 1'b0);
        den <= 1'b0;
        ins(BPA, 4'h0, 1'b0, 1'b0);
        $display("monitor done");
    endtask
    task automatic t_vcatch();
        wreg(`DEG_ADDR_CTRL, 32'h0000_0009);
        den <= 1'b1;
        @(posedge i_clk_sys) vec <= 1'b1;
        @(posedge i_clk_sys) vec <= 1'b0;
        #1 chk({31'h0, exc}, 32'h0000_0000);
        nar <= 1'b1;
        st1 <= 1'b1;
        @(posedge i_clk_sys) vec <= 1'b1;
        @(posedge i_clk_sys) vec <= 1'b0;
        #1 chk({31'h0, exc}, 32'h0000_0001);
        nar <= 1'b0;
        st1 <= 1'b0;
        $display("vcatch done");
    endtask
    task automatic t_step();
        wreg(`DEG_ADDR_CTRL, 32'h0000_0005);
        ins(32'h0000_0100, 4'h0, 1'b0, 1'b0);
        ins(32'h0000_0104, 4'h0, 1'b1, 1'b0);
        den <= 1'b0;
        ins(32'h0000_0108, 4'h0, 1'b0, 1'b0);
        ins(32'h0000_010C, 4'h0, 1'b0, 1'b0);
        $display("step done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {i_rstn, wr, rd, iv, hent, wbrk, nbrk, oexc, dv, df, ds} = 11'h000;
        {sec, nar, st1, vec, den} = 5'h00;
        ra = 4'h0;
        {wd, ia, da} = 96'h0;
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        t_regs();
        t_brk();
        t_halt();
        t_secure();
        t_mon();
        t_vcatch();
        t_step();
        tally_and_finish();
    end
endmodule
